// *** design/chgi_serial_port.sv ***
// Purpose: Serial control port slave with the charger register file.
// Assumes: scl_clk is the bus clock pin used as a clock; host is master.
// Notes:   Link logic runs on SCL edges, registers on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module chgi_serial_port #(
  parameter logic [7:0] IDENT_CODE = 8'h48  // Arbitrary value
) (
  // System clock, reset, enable
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       ce,
  // Two-wire bus
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Asynchronous pins and protection events
  input  wire logic       otg_pin,
  input  wire logic       bus_overvoltage_event,
  input  wire logic       battery_overvoltage_event,
  input  wire logic       peak_limit_event,
  // Charger core status, same clock
  input  wire logic [1:0] core_stat,
  input  wire logic [2:0] core_fault,
  // Configuration and control outputs
  output logic            boost_select_bit,
  output logic            boost_switch_driver,
  output logic            en_stat,
  output logic            timer_restart,
  output logic [7:0]      cfg_limit,
  output logic [7:0]      cfg_vreg,
  output logic [7:0]      cfg_term,
  output logic [7:0]      cfg_special,
  output logic [7:0]      cfg_safety
);

  // Two domains meet here. The link side runs on SCL edges and hands
  // words over by flipping a toggle; the system side waits for the
  // toggle to pass its synchroniser before reading the word, which by
  // then has stood still for several system clocks.
  // Limitation: with ce low for a whole byte time a toggle may flip
  // twice, and a write or a fetch is then missed.

  // Link state sampled on SCL rising edges
  typedef struct packed {
    chgi_pkg::chgi_phase_t phase;
    logic [3:0]            bitcnt;
    logic [7:0]            shreg;
    logic                  rw;
    logic [7:0]            ptr;
    logic                  start_ack;
    logic                  stop_ack;
    logic                  wr_tog;
    logic                  addr_tog;
    logic [7:0]            wr_addr;
    logic [7:0]            wr_data;
  } chgi_link_t;

  // Driver state updated on SCL falling edges
  typedef struct packed {
    logic [7:0] tx;
    logic       oe;
  } chgi_drv_t;

  // System domain state
  typedef struct packed {
    logic [chgi_pkg::CHGI_SY_N-1:0] sy1;
    logic [chgi_pkg::CHGI_SY_N-1:0] sy2;
    logic [1:0]                     sy3;
    logic                           en_stat;
    logic                           tmr;
    logic [7:0]                     limit;
    logic [7:0]                     vreg;
    logic [7:0]                     term;
    logic [7:0]                     special;
    logic [7:0]                     safety;
    logic                           bus_trip;
    logic                           bat_trip;
    logic                           drive;
    logic [7:0]                     rd_data;
  } chgi_sys_t;

  chgi_link_t lk;
  chgi_link_t next_lk;
  chgi_drv_t  dv;
  chgi_drv_t  next_dv;
  chgi_sys_t  sy;
  chgi_sys_t  next_sy;
  logic       start_tog;
  logic       stop_tog;
  logic [7:0] rx_byte;
  logic       addr_hit;
  logic [7:0] status_byte;

  // Start and stop seen on SDA edges while SCL is high; only toggles leave
  always_ff @(negedge sda_in or negedge resetn) begin
    if (!resetn) begin
      start_tog <= 1'b0;
    end else if (scl_clk) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge sda_in or negedge resetn) begin
    if (!resetn) begin
      stop_tog <= 1'b0;
    end else if (scl_clk) begin
      stop_tog <= ~stop_tog;
    end
  end

  // Byte being completed by the bit sampled on this edge
  assign rx_byte = {lk.shreg[6:0], sda_in};

  // Own address completes on the eighth rising edge of the first byte
  assign addr_hit = (rx_byte[7:1] == chgi_pkg::CHGI_DEV_ADDR);

  // Link receiver; every decision is made on SCL, but the hand-over to clk_sys bounds the bus rate
  always_comb begin
    next_lk = lk;
    if (start_tog != lk.start_ack) begin
      // First address bit rides on the first rising edge after start
      next_lk.start_ack = start_tog;
      next_lk.stop_ack  = stop_tog;
      next_lk.shreg     = {7'h00, sda_in};
      next_lk.bitcnt    = chgi_pkg::CHGI_FIRST_BIT;
      next_lk.phase     = chgi_pkg::CHGI_ADDR;
    end else if (stop_tog != lk.stop_ack) begin
      // A partial byte is left in the shifter and never committed
      // A bus stop is seen at the next rise, which only a start brings
      next_lk.stop_ack = stop_tog;
      next_lk.phase    = chgi_pkg::CHGI_IDLE;
    end else begin
      unique case (lk.phase)
        chgi_pkg::CHGI_IDLE: begin
          // Everything is ignored until the start branch above fires
          next_lk.bitcnt = 4'h0;
        end
        chgi_pkg::CHGI_ADDR, chgi_pkg::CHGI_SUB,
        chgi_pkg::CHGI_WDATA: begin
          if (lk.bitcnt != chgi_pkg::CHGI_ACK_SLOT) begin
            next_lk.shreg  = rx_byte;
            next_lk.bitcnt = lk.bitcnt + 4'h1;
            if (lk.bitcnt == chgi_pkg::CHGI_LAST_BIT) begin
              if (lk.phase == chgi_pkg::CHGI_ADDR) begin
                next_lk.rw = rx_byte[0];
                if (!addr_hit) begin
                  next_lk.phase = chgi_pkg::CHGI_IDLE;
                end
              end else if (lk.phase == chgi_pkg::CHGI_SUB) begin
                next_lk.ptr      = rx_byte;
                next_lk.addr_tog = ~lk.addr_tog;
              end else begin
                // Only a whole byte is handed to the register file
                next_lk.wr_addr = lk.ptr;
                next_lk.wr_data = rx_byte;
                next_lk.wr_tog  = ~lk.wr_tog;
              end
            end
          end else begin
            next_lk.bitcnt = 4'h0;
            if (lk.phase == chgi_pkg::CHGI_ADDR) begin
              next_lk.phase = lk.rw ? chgi_pkg::CHGI_RDATA
                                    : chgi_pkg::CHGI_SUB;
            end else if (lk.phase == chgi_pkg::CHGI_SUB) begin
              next_lk.phase = chgi_pkg::CHGI_WDATA;
            end else begin
              // Sub-address wraps after 0xff, so no byte count limit
              next_lk.ptr      = lk.ptr + 8'h01;
              next_lk.addr_tog = ~lk.addr_tog;
            end
          end
        end
        chgi_pkg::CHGI_RDATA: begin
          if (lk.bitcnt != chgi_pkg::CHGI_ACK_SLOT) begin
            next_lk.bitcnt = lk.bitcnt + 4'h1;
          end else if (sda_in) begin
            next_lk.phase = chgi_pkg::CHGI_IDLE;
          end else begin
            next_lk.bitcnt   = 4'h0;
            next_lk.ptr      = lk.ptr + 8'h01;
            next_lk.addr_tog = ~lk.addr_tog;
          end
        end
        default: begin
          next_lk.phase = chgi_pkg::CHGI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      lk <= '{phase: chgi_pkg::CHGI_IDLE, default: '0};
    end else begin
      lk <= next_lk;
    end
  end

  // SDA driver; moves only on falling SCL so it never fakes start or stop
  always_comb begin
    next_dv    = dv;
    next_dv.oe = 1'b0;
    if (start_tog != lk.start_ack) begin
      next_dv.oe = 1'b0;
    end else if (lk.bitcnt == chgi_pkg::CHGI_ACK_SLOT &&
                 (lk.phase == chgi_pkg::CHGI_ADDR ||
                  lk.phase == chgi_pkg::CHGI_SUB ||
                  lk.phase == chgi_pkg::CHGI_WDATA)) begin
      next_dv.oe = 1'b1;
    end else if (lk.phase == chgi_pkg::CHGI_RDATA &&
                 lk.bitcnt != chgi_pkg::CHGI_ACK_SLOT) begin
      if (lk.bitcnt == 4'h0) begin
        // Read byte is latched once so it cannot change mid-byte
        // In a burst the next byte is fetched after the master's ack,
        // so that SCL high time must exceed three system clocks
        next_dv.tx = sy.rd_data;
        next_dv.oe = ~sy.rd_data[7];
      end else begin
        next_dv.oe = ~dv.tx[~lk.bitcnt[2:0]];
      end
    end
  end

  always_ff @(negedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      dv <= '0;
    end else begin
      dv <= next_dv;
    end
  end

  // Open-drain pin: only ever pulls low, never drives high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // The enable is the only pin driver; the pull-up gives the high level
  assign sda_oe = dv.oe;

  // Status byte assembled from live state; trips override the core state, only the bus trip the fault code
  assign status_byte = {
    sy.sy2[chgi_pkg::CHGI_SY_OTG],
    sy.en_stat,
    (sy.bus_trip | sy.bat_trip) ? chgi_pkg::CHGI_STAT_FAULT : core_stat,
    sy.limit[chgi_pkg::CHGI_BOOST_BIT],
    sy.bus_trip ? chgi_pkg::CHGI_FAULT_BUS : core_fault
  };

  // Register file; link words are read only after their toggle synchronises
  always_comb begin
    next_sy     = sy;
    next_sy.sy1 = {peak_limit_event,
                   battery_overvoltage_event,
                   bus_overvoltage_event,
                   otg_pin,
                   lk.addr_tog,
                   lk.wr_tog};
    next_sy.sy2 = sy.sy1;
    next_sy.sy3 = sy.sy2[chgi_pkg::CHGI_SY_ADDR:chgi_pkg::CHGI_SY_WR];
    next_sy.tmr = 1'b0;
    if (sy.sy2[chgi_pkg::CHGI_SY_WR] != sy.sy3[chgi_pkg::CHGI_SY_WR]) begin
      unique case (lk.wr_addr)
        chgi_pkg::CHGI_REG_STATUS: begin
          next_sy.en_stat = lk.wr_data[chgi_pkg::CHGI_EN_BIT];
          next_sy.tmr     = lk.wr_data[chgi_pkg::CHGI_TMR_BIT];
        end
        chgi_pkg::CHGI_REG_LIMIT: begin
          next_sy.limit = lk.wr_data;
          // Trips hold until the host sets the select bit again
          if (lk.wr_data[chgi_pkg::CHGI_BOOST_BIT]) begin
            next_sy.bus_trip = 1'b0;
            next_sy.bat_trip = 1'b0;
          end
        end
        chgi_pkg::CHGI_REG_VREG:    next_sy.vreg    = lk.wr_data;
        chgi_pkg::CHGI_REG_TERM:    next_sy.term    = lk.wr_data;
        chgi_pkg::CHGI_REG_SPECIAL: next_sy.special = lk.wr_data;
        chgi_pkg::CHGI_REG_SAFETY:  next_sy.safety  = lk.wr_data;
        default: begin
          next_sy.tmr = 1'b0;
        end
      endcase
    end
    // While boost is selected, protection events win over a host write in the same cycle
    if (sy.limit[chgi_pkg::CHGI_BOOST_BIT]) begin
      if (sy.sy2[chgi_pkg::CHGI_SY_BUS]) begin
        next_sy.bus_trip = 1'b1;
        next_sy.limit[chgi_pkg::CHGI_BOOST_BIT] = 1'b0;
      end
      if (sy.sy2[chgi_pkg::CHGI_SY_BAT]) begin
        next_sy.bat_trip = 1'b1;
        next_sy.limit[chgi_pkg::CHGI_BOOST_BIT] = 1'b0;
      end
    end
    // Switch stops in the cycle the trip clears the select bit
    next_sy.drive = next_sy.limit[chgi_pkg::CHGI_BOOST_BIT] &
                    ~sy.sy2[chgi_pkg::CHGI_SY_PEAK];
    if (sy.sy2[chgi_pkg::CHGI_SY_ADDR] != sy.sy3[chgi_pkg::CHGI_SY_ADDR]) begin
      unique case (lk.ptr)
        chgi_pkg::CHGI_REG_STATUS:  next_sy.rd_data = status_byte;
        chgi_pkg::CHGI_REG_LIMIT:   next_sy.rd_data = sy.limit;
        chgi_pkg::CHGI_REG_VREG:    next_sy.rd_data = sy.vreg;
        chgi_pkg::CHGI_REG_IDENT:   next_sy.rd_data = IDENT_CODE;
        chgi_pkg::CHGI_REG_TERM:    next_sy.rd_data = sy.term;
        chgi_pkg::CHGI_REG_SPECIAL: next_sy.rd_data = sy.special;
        chgi_pkg::CHGI_REG_SAFETY:  next_sy.rd_data = sy.safety;
        default:                    next_sy.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sy <= '{limit:   chgi_pkg::CHGI_RST_LIMIT,
              vreg:    chgi_pkg::CHGI_RST_VREG,
              term:    chgi_pkg::CHGI_RST_TERM,
              special: chgi_pkg::CHGI_RST_SPECIAL,
              safety:  chgi_pkg::CHGI_RST_SAFETY,
              default: '0};
    end else if (ce) begin
      sy <= next_sy;
    end
  end

  // Outputs straight from system flops
  // Configuration bytes go to the charger core with no further decode
  assign boost_select_bit    = sy.limit[chgi_pkg::CHGI_BOOST_BIT];
  assign boost_switch_driver = sy.drive;
  assign en_stat             = sy.en_stat;
  assign timer_restart       = sy.tmr;
  assign cfg_limit           = sy.limit;
  assign cfg_vreg            = sy.vreg;
  assign cfg_term            = sy.term;
  assign cfg_special         = sy.special;
  assign cfg_safety          = sy.safety;

endmodule
`default_nettype wire

// *** design/chgi_pkg.sv ***
// Purpose: Shared constants and types for the charger serial control port.
// Assumes: Register map of seven bytes, slave address fixed, SCL as clock.
// Notes:   How it works is listed below, one line per point.
// How it works
// - Slave runs at 100 kHz, 400 kHz and 3.4 Mbit/s rates.
// - Slave only: no arbitration, no clock stretching, no wait states.
// - Bytes move MSB first, eight bits, one bit per clock.
// - Receiver returns an acknowledge in the clock after each byte.
// - SDA falling with SCL high is start, rising is stop; both detected.
// - Data bits change only while SCL is low.
// - Device holds SDA low for the whole acknowledge clock.
// - Device answers slave address 1101010 with a direction bit.
// - Write: address+0, ack, sub-address, ack, data, ack, stop.
// - Read: set sub-address, repeated start, address+1, ack, data byte.
// - Single-byte reads and writes accepted for sub-addresses 0x00 to 0xFF.
// - Sequential write starts at sub-address, each byte goes to next.
// - An incomplete final byte is dropped; complete bytes are kept.
// - No limit on bytes between start and stop.
// - Bus overvoltage in boost: state 11, fault 001, boost select cleared.
// - Battery overvoltage in boost: state 11, boost select cleared.
// - Peak current limit in boost holds the boost switch driver off.
package chgi_pkg;

  // Slave address and byte framing
  localparam logic [6:0] CHGI_DEV_ADDR  = 7'h6a;
  localparam logic [3:0] CHGI_LAST_BIT  = 4'h7;
  localparam logic [3:0] CHGI_ACK_SLOT  = 4'h8;
  localparam logic [3:0] CHGI_FIRST_BIT = 4'h1;

  // Register offsets
  localparam logic [7:0] CHGI_REG_STATUS  = 8'h00;
  localparam logic [7:0] CHGI_REG_LIMIT   = 8'h01;
  localparam logic [7:0] CHGI_REG_VREG    = 8'h02;
  localparam logic [7:0] CHGI_REG_IDENT   = 8'h03;
  localparam logic [7:0] CHGI_REG_TERM    = 8'h04;
  localparam logic [7:0] CHGI_REG_SPECIAL = 8'h05;
  localparam logic [7:0] CHGI_REG_SAFETY  = 8'h06;

  // Reset values
  localparam logic [7:0] CHGI_RST_LIMIT   = 8'h70;
  localparam logic [7:0] CHGI_RST_VREG    = 8'h0a;
  localparam logic [7:0] CHGI_RST_TERM    = 8'h01;
  localparam logic [7:0] CHGI_RST_SPECIAL = 8'h24;
  localparam logic [7:0] CHGI_RST_SAFETY  = 8'hc0;

  // Field positions in status and limit registers
  localparam int CHGI_TMR_BIT   = 7;
  localparam int CHGI_EN_BIT    = 6;
  localparam int CHGI_BOOST_BIT = 0;

  // Field codes written by protection events
  localparam logic [1:0] CHGI_STAT_FAULT = 2'h3;
  localparam logic [2:0] CHGI_FAULT_BUS  = 3'h1;

  // Index of each bit in the input synchroniser vector
  localparam int CHGI_SY_WR   = 0;
  localparam int CHGI_SY_ADDR = 1;
  localparam int CHGI_SY_OTG  = 2;
  localparam int CHGI_SY_BUS  = 3;
  localparam int CHGI_SY_BAT  = 4;
  localparam int CHGI_SY_PEAK = 5;
  localparam int CHGI_SY_N    = 6;

  // Link byte phase, one-hot
  typedef enum logic [4:0] {
    CHGI_IDLE  = 5'h01,
    CHGI_ADDR  = 5'h02,
    CHGI_SUB   = 5'h04,
    CHGI_WDATA = 5'h08,
    CHGI_RDATA = 5'h10
  } chgi_phase_t;

endpackage

// *** tb/chgi_port_assertions.sv ***
// Purpose: Port assertions for the charger serial control port.
// Assumes: Event pins pass a 2FF synchroniser before use.
// Notes:   Bound to every chgi_serial_port instance.
`timescale 1ns/1ps
`default_nettype none
module chgi_port_chk (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_clk,
  // Watched pins
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic peak_limit_event,
  input wire logic bus_overvoltage_event,
  input wire logic battery_overvoltage_event,
  input wire logic boost_select_bit,
  input wire logic boost_switch_driver,
  input wire logic timer_restart
);
  logic       oe_rise;
  logic [3:0] oe_run;
  // Pin level seen through the high phase, and its run length
  always_ff @(posedge scl_clk or negedge resetn) begin
    if (!resetn) begin
      oe_rise <= 1'b0;
      oe_run  <= 4'h0;
    end else begin
      oe_rise <= sda_oe;
      oe_run  <= sda_oe ? oe_run + 4'h1 : 4'h0;
    end
  end
  chk_ack_steady: assert property (@(negedge scl_clk)
    disable iff (!resetn) sda_oe == oe_rise)
    else $error("sda_oe moved while scl high");
  chk_drive_low: assert property (@(posedge clk_sys)
    disable iff (!resetn) sda_out == 1'b0)
    else $error("sda driven high");
  // Ack plus eight zero bits is the longest legal pull
  chk_oe_released: assert property (@(posedge scl_clk)
    disable iff (!resetn) oe_run <= 4'h9)
    else $error("sda held past its slot");
  chk_driver_sel: assert property (@(posedge clk_sys)
    disable iff (!resetn) boost_switch_driver |-> boost_select_bit)
    else $error("driver on without boost select");
  chk_peak_off: assert property (@(posedge clk_sys)
    disable iff (!resetn) peak_limit_event [*5] |-> !boost_switch_driver)
    else $error("driver on during peak limit");
  chk_peak_resume: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    (!peak_limit_event && boost_select_bit) [*5] |-> boost_switch_driver)
    else $error("driver did not resume");
  chk_bus_ov_clear: assert property (@(posedge clk_sys)
    disable iff (!resetn) bus_overvoltage_event [*5] |-> !boost_select_bit)
    else $error("boost select kept on bus overvoltage");
  chk_bat_ov_clear: assert property (@(posedge clk_sys)
    disable iff (!resetn)
    battery_overvoltage_event [*5] |-> !boost_select_bit)
    else $error("boost select kept on battery overvoltage");
  cov_ack: cover property (@(posedge scl_clk) disable iff (!resetn)
    $rose(sda_oe));
  cov_trip: cover property (@(posedge clk_sys) disable iff (!resetn)
    $fell(boost_select_bit));
  cov_timer: cover property (@(posedge clk_sys) disable iff (!resetn)
    timer_restart);
endmodule
bind chgi_serial_port chgi_port_chk chgi_port_chk_i (
  .clk_sys(clk_sys), .resetn(resetn), .scl_clk(scl_clk),
  .sda_out(sda_out), .sda_oe(sda_oe), .peak_limit_event(peak_limit_event),
  .bus_overvoltage_event(bus_overvoltage_event),
  .battery_overvoltage_event(battery_overvoltage_event),
  .boost_select_bit(boost_select_bit),
  .boost_switch_driver(boost_switch_driver),
  .timer_restart(timer_restart));
`default_nettype wire

// *** tb/chgi_host_model.sv ***
// Purpose: Behavioural bus host framing transfers for the port.
// Assumes: SDA has a pull-up; SCL rests high between frames.
// Notes:   SCL period 30 ns, data moves in the low phase.
`timescale 1ns/1ps
`default_nettype none
module chgi_host_model (
  // Bus wires
  output var logic scl_clk,
  output var logic sda_low,
  input  wire logic sda
);
  // Bus rests released
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: SDA falls while SCL high
  task automatic start_cond();
    sda_low = 1'b0;
    #7 scl_clk = 1'b1;
    #8 sda_low = 1'b1;
    #7 scl_clk = 1'b0;
    #8;
  endtask
  // Stop, after which SCL stands still
  task automatic stop_cond();
    sda_low = 1'b1;
    #7 scl_clk = 1'b1;
    #8 sda_low = 1'b0;
    #15;
  endtask
  // One clock: data set while SCL low, line read mid high
  task automatic bit_slot(input logic b, output logic seen);
    sda_low = ~b;
    #7 scl_clk = 1'b1;
    #7 seen = sda;
    #8 scl_clk = 1'b0;
    #8;
  endtask
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(v[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  // Read a byte, then ACK (last low) or NAK (last high)
  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, v[i]);
    bit_slot(last, s);
  endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the charger serial control port.
// Assumes: Host model clocks SCL only within frames.
// Notes:   Register writes land a few system clocks after the byte.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] ID_VAL = 8'h5c; // Arbitrary value
  localparam logic [7:0] WR_ADR = {chgi_pkg::CHGI_DEV_ADDR, 1'b0};
  // Bench-driven inputs
  logic       clk_sys    = 1'b0;
  logic       resetn;
  logic       ce         = 1'b1;
  logic       otg_pin    = 1'b1;
  logic       bus_ov     = 1'b0;
  logic       bat_ov     = 1'b0;
  logic       peak       = 1'b0;
  logic [1:0] core_stat  = 2'h0;
  logic [2:0] core_fault = 3'h0;
  // Observed nets
  wire        scl_clk, sda_low, sda_out, sda_oe, sda, sel, drv, en_stat, tmr;
  wire  [7:0] lim, vreg, term, spec, safe;
  int         n_fail;
  int         total_checks;
  int         n_tmr = 0;
  // Open-drain wire with pull-up
  assign sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  always #20 clk_sys = ~clk_sys;
  chgi_host_model chgi_host_model_i (
    .scl_clk(scl_clk), .sda_low(sda_low), .sda(sda));
  chgi_serial_port #(.IDENT_CODE(ID_VAL)) chgi_serial_port_i (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .scl_clk(scl_clk),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .otg_pin(otg_pin),
    .bus_overvoltage_event(bus_ov), .battery_overvoltage_event(bat_ov),
    .peak_limit_event(peak), .core_stat(core_stat),
    .core_fault(core_fault), .boost_select_bit(sel),
    .boost_switch_driver(drv), .en_stat(en_stat), .timer_restart(tmr),
    .cfg_limit(lim), .cfg_vreg(vreg), .cfg_term(term),
    .cfg_special(spec), .cfg_safety(safe));
  // Count timer restart pulses; each lasts one system clock
  always @(posedge clk_sys) begin
    if (tmr === 1'b1) n_tmr++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s %h not %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Commit crosses to the system clock in a few cycles
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic put(input logic [7:0] d, input logic want);
    logic a;
    chgi_host_model_i.send_byte(d, a);
    check({7'h0, a}, {7'h0, want}, "ack");
  endtask
  task automatic open_wr(input logic [7:0] sub);
    chgi_host_model_i.start_cond();
    put(WR_ADR, 1'b1);
    put(sub, 1'b1);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    open_wr(sub);
    put(d, 1'b1);
    chgi_host_model_i.stop_cond();
    settle();
  endtask
  task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] d;
    open_wr(sub);
    chgi_host_model_i.start_cond();
    put(WR_ADR | 8'h01, 1'b1);
    chgi_host_model_i.recv_byte(1'b1, d);
    chgi_host_model_i.stop_cond();
    settle();
    check(d, exp, "read");
  endtask
  // Reset values, single writes and reads across the map
  task automatic s_single();
    check(lim, chgi_pkg::CHGI_RST_LIMIT, "limit reset");
    check(safe, chgi_pkg::CHGI_RST_SAFETY, "safety reset");
    wr(chgi_pkg::CHGI_REG_VREG, 8'h2d);
    check(vreg, 8'h2d, "vreg");
    rd_chk(chgi_pkg::CHGI_REG_VREG, 8'h2d);
    @(posedge clk_sys) ce <= 1'b0;
    wr(chgi_pkg::CHGI_REG_VREG, 8'h3c);
    check(vreg, 8'h2d, "vreg frozen");
    @(posedge clk_sys) ce <= 1'b1;
    settle();
    check(vreg, 8'h3c, "vreg thawed");
    wr(chgi_pkg::CHGI_REG_IDENT, 8'ha5);
    rd_chk(chgi_pkg::CHGI_REG_IDENT, ID_VAL);
    wr(8'hff, 8'ha5);
    rd_chk(8'hff, 8'h00);
  endtask
  // Burst write, then a burst cut short in mid byte
  task automatic s_seq();
    logic s;
    open_wr(chgi_pkg::CHGI_REG_TERM);
    put(8'h11, 1'b1);
    put(8'h22, 1'b1);
    put(8'h33, 1'b1);
    chgi_host_model_i.stop_cond();
    settle();
    check(term, 8'h11, "term");
    check(spec, 8'h22, "special");
    check(safe, 8'h33, "safety");
    open_wr(chgi_pkg::CHGI_REG_TERM);
    put(8'h44, 1'b1);
    for (int i = 0; i < 4; i++) chgi_host_model_i.bit_slot(1'b0, s);
    chgi_host_model_i.stop_cond();
    settle();
    check(term, 8'h44, "term kept");
    check(spec, 8'h22, "partial byte");
  endtask
  // Neighbouring address must be ignored whole
  task automatic s_other_addr();
    chgi_host_model_i.start_cond();
    put(8'hd6, 1'b0);
    put(chgi_pkg::CHGI_REG_VREG, 1'b0);
    put(8'h00, 1'b0);
    chgi_host_model_i.stop_cond();
    settle();
    check(vreg, 8'h3c, "foreign write");
  endtask
  // Boost select, peak limit and both overvoltage trips
  task automatic s_boost();
    wr(chgi_pkg::CHGI_REG_STATUS, 8'hc0);
    check({7'h0, en_stat}, 8'h01, "en_stat");
    check(n_tmr[7:0], 8'h01, "timer restart");
    wr(chgi_pkg::CHGI_REG_LIMIT, 8'h71);
    check({6'h0, sel, drv}, 8'h03, "boost on");
    @(posedge clk_sys) peak <= 1'b1;
    settle();
    check({6'h0, sel, drv}, 8'h02, "peak off");
    @(posedge clk_sys) peak <= 1'b0;
    settle();
    check({6'h0, sel, drv}, 8'h03, "peak over");
    @(posedge clk_sys) bus_ov <= 1'b1;
    settle();
    check({6'h0, sel, drv}, 8'h00, "bus trip");
    @(posedge clk_sys) bus_ov <= 1'b0;
    rd_chk(chgi_pkg::CHGI_REG_STATUS, 8'hf1);
    wr(chgi_pkg::CHGI_REG_LIMIT, 8'h71);
    @(posedge clk_sys) core_fault <= 3'h4;
    @(posedge clk_sys) bat_ov <= 1'b1;
    settle();
    check({6'h0, sel, drv}, 8'h00, "battery trip");
    @(posedge clk_sys) bat_ov <= 1'b0;
    rd_chk(chgi_pkg::CHGI_REG_STATUS, 8'hf4);
  endtask
  initial begin
    n_fail = 0;
    total_checks = 0;
    resetn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    settle();
    s_single();
    s_seq();
    s_other_addr();
    s_boost();
    results();
  end
  // Watchdog against a stuck run
  initial begin
    for (int i = 0; i < 5000; i++) @(posedge clk_sys);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
